//--- inc/mig_pkg.sv
// Constants and carrier types of the motion index and gear command interpreter.
// Assumes one drive clock, an active-low asynchronous reset and plain status ports.
// Summary of operation
// RL1: Accepted flag set on request rise, held
// RL2: Done flag set when transaction completes
// RL3: Error flag on failure, cause code reported
// RL4: In-progress after run issued, until target reached
// RL5: Complete when in-progress, issued and reached
// RL6: Index selects one of 99 stored programs
// RL7: Out-of-range index rejected with code 115
// RL8: Executing program index always output
// RL9: Codes 100 not ready, 101 fault, 105 disabled
// RL10: Codes 103/107 stopping, 108 other source
// RL11: Code 127 previous busy, 129 no motor
// RL12: Gear follow scales master pulses by ratio
// RL13: Controller sets numerator to feedback resolution
// RL14: Denominator pulses give one motor revolution
// RL15: Fixed policy default keeps existing ratio
// RL16: Variable policy loads new ratio from counts
// RL17: Controller should home after variable gearing
// RL18: Four selectable ratios; network command ignores them
// RL19: Program configured before cyclic connection
// RL20: Gear in-progress held while gearing active
// RL21: Error code held until next request rise
package mig_pkg;

  localparam int unsigned IDX_W = 7;
  localparam int unsigned ERR_W = 8;
  localparam int unsigned CNT_W = 32;
  localparam logic [IDX_W-1:0] IDX_MIN = 7'h01;
  localparam logic [IDX_W-1:0] IDX_MAX = 7'h63;
  localparam logic [IDX_W-1:0] IDX_NONE = 7'h00;
  localparam logic [ERR_W-1:0] ERR_NONE = 8'h00;
  localparam logic [ERR_W-1:0] ERR_NOT_READY = 8'h64;
  localparam logic [ERR_W-1:0] ERR_FAULTED = 8'h65;
  localparam logic [ERR_W-1:0] ERR_SERVO_OFF = 8'h67;
  localparam logic [ERR_W-1:0] ERR_DISABLED = 8'h69;
  localparam logic [ERR_W-1:0] ERR_AXIS_STOP = 8'h6B;
  localparam logic [ERR_W-1:0] ERR_OTHER_SRC = 8'h6C;
  localparam logic [ERR_W-1:0] ERR_BAD_INDEX = 8'h73;
  localparam logic [ERR_W-1:0] ERR_PREV_BUSY = 8'h7F;
  localparam logic [ERR_W-1:0] ERR_NO_MOTOR = 8'h81;
  localparam logic [CNT_W-1:0] DEF_NUM = 32'h0000_0001;
  localparam logic [CNT_W-1:0] DEF_DEN = 32'h0000_0001;
  localparam logic POLICY_FIXED = 1'b0;

  // Drive condition inputs that gate command acceptance.
  typedef struct packed {
    logic ready;
    logic faulted;
    logic enabled;
    logic servo_off_busy;
    logic axis_stop_busy;
    logic other_src_busy;
    logic motor_present;
  } mig_drive_t;

  // Handshake status flags reported to the controller.
  typedef struct packed {
    logic accepted;
    logic done;
    logic error;
    logic in_progress;
    logic complete;
  } mig_status_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RUN,
    ST_GEAR,
    ST_HOLD
  } mig_state_t;

endpackage : mig_pkg

//--- src/mig_command.sv
// Command interpreter: program-run by index and gear follow through an electronic gear ratio.
// Assumes request and drive condition inputs come from outside and are synchronised here;
// master pulses arrive as a level on a pin and are synchronised and edge-detected.
`timescale 1ns/1ns
module mig_command (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic run_request,
  input wire logic gear_request,
  input wire logic [mig_pkg::IDX_W-1:0] program_index_request,
  input wire mig_pkg::mig_drive_t drive_cond,
  input wire logic target_reached_flag,
  input wire logic master_pulse,
  input wire logic gear_ratio_policy,
  input wire logic [mig_pkg::CNT_W-1:0] gear_numerator_counts,
  input wire logic [mig_pkg::CNT_W-1:0] gear_denominator_counts,
  input wire logic [1:0] gear_select_inputs,
  output logic command_accepted_flag,
  output logic transfer_done_flag,
  output logic command_error_flag,
  output logic motion_in_progress_flag,
  output logic motion_complete_flag,
  output logic [mig_pkg::ERR_W-1:0] error_cause_code,
  output logic [mig_pkg::IDX_W-1:0] executing_program_index,
  output logic program_run_command,
  output logic [mig_pkg::IDX_W-1:0] stored_motion_program,
  output logic pulse_follow_mode,
  output logic motor_step_pulse,
  output logic [mig_pkg::CNT_W-1:0] active_gear_numerator,
  output logic [mig_pkg::CNT_W-1:0] active_gear_denominator
);

  typedef struct packed {
    logic [1:0] run_s;
    logic [1:0] gear_s;
    logic [1:0] tr_s;
    logic [1:0] pul_s;
    logic [13:0] cond_s;
    logic run_q;
    logic gear_q;
    logic pul_q;
    mig_pkg::mig_state_t st;
    mig_pkg::mig_status_t sts;
    logic [mig_pkg::ERR_W-1:0] err;
    logic [mig_pkg::IDX_W-1:0] exec_idx;
    logic issue;
    logic [mig_pkg::IDX_W-1:0] prog;
    logic [mig_pkg::CNT_W-1:0] num;
    logic [mig_pkg::CNT_W-1:0] den;
    logic [mig_pkg::CNT_W-1:0] acc;
    logic step;
    logic follow;
  } mig_core_t;

  mig_core_t cur_ff;
  mig_core_t nxt_cur;

  ////////////////////////////////////////////////////////////////////////////////
  // Pick the first rejection cause in priority order; none means accepted.
  function automatic logic [mig_pkg::ERR_W-1:0] reject_code(
    input mig_pkg::mig_drive_t d,
    input logic busy,
    input logic check_idx,
    input logic [mig_pkg::IDX_W-1:0] idx
  );
    logic [mig_pkg::ERR_W-1:0] code;
    code = mig_pkg::ERR_NONE;
    if (!d.motor_present) code = mig_pkg::ERR_NO_MOTOR; // RL11
    else if (d.faulted) code = mig_pkg::ERR_FAULTED; // RL9
    else if (!d.ready) code = mig_pkg::ERR_NOT_READY; // RL9
    else if (!d.enabled) code = mig_pkg::ERR_DISABLED; // RL9
    else if (d.servo_off_busy) code = mig_pkg::ERR_SERVO_OFF; // RL10
    else if (d.axis_stop_busy) code = mig_pkg::ERR_AXIS_STOP; // RL10
    else if (d.other_src_busy) code = mig_pkg::ERR_OTHER_SRC; // RL10
    else if (busy) code = mig_pkg::ERR_PREV_BUSY; // RL11
    else if (check_idx && (idx < mig_pkg::IDX_MIN || idx > mig_pkg::IDX_MAX)) begin
      code = mig_pkg::ERR_BAD_INDEX; // RL7
    end
    return code;
  endfunction : reject_code

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic for the whole interpreter.
  always_comb begin
    logic run_rise;
    logic gear_rise;
    logic pul_rise;
    logic busy;
    logic [mig_pkg::ERR_W-1:0] code;
    logic [mig_pkg::CNT_W:0] sum;
    mig_pkg::mig_drive_t dc;
    nxt_cur = cur_ff;
    nxt_cur.run_s = {cur_ff.run_s[0], run_request};
    nxt_cur.gear_s = {cur_ff.gear_s[0], gear_request};
    nxt_cur.tr_s = {cur_ff.tr_s[0], target_reached_flag};
    nxt_cur.pul_s = {cur_ff.pul_s[0], master_pulse};
    nxt_cur.cond_s = {cur_ff.cond_s[6:0], drive_cond};
    nxt_cur.run_q = cur_ff.run_s[1];
    nxt_cur.gear_q = cur_ff.gear_s[1];
    nxt_cur.pul_q = cur_ff.pul_s[1];
    dc = mig_pkg::mig_drive_t'(cur_ff.cond_s[13:7]);
    run_rise = cur_ff.run_s[1] && !cur_ff.run_q;
    gear_rise = cur_ff.gear_s[1] && !cur_ff.gear_q;
    pul_rise = cur_ff.pul_s[1] && !cur_ff.pul_q;
    busy = (cur_ff.st != mig_pkg::ST_IDLE);
    code = mig_pkg::ERR_NONE;
    sum = '0;
    nxt_cur.issue = 1'b0;
    nxt_cur.step = 1'b0;
    // A new request rise clears the previous result; the held code lives until then.
    if (run_rise || gear_rise) begin
      nxt_cur.sts.done = 1'b0; // RL21
      nxt_cur.sts.error = 1'b0; // RL21
      nxt_cur.sts.complete = 1'b0;
      nxt_cur.err = mig_pkg::ERR_NONE; // RL21
      code = reject_code(dc, busy, run_rise, program_index_request);
      nxt_cur.sts.accepted = 1'b1; // RL1
      if (code != mig_pkg::ERR_NONE) begin
        nxt_cur.sts.error = 1'b1; // RL3
        nxt_cur.err = code; // RL3
      end else if (run_rise) begin
        nxt_cur.prog = program_index_request; // RL6
        nxt_cur.issue = 1'b1;
        nxt_cur.exec_idx = program_index_request; // RL8
        nxt_cur.sts.done = 1'b1; // RL2
        nxt_cur.sts.in_progress = 1'b1; // RL4
        nxt_cur.st = mig_pkg::ST_RUN;
      end else begin
        // Gear-select inputs are deliberately ignored by the network command.
        if (gear_ratio_policy != mig_pkg::POLICY_FIXED) begin // RL18
          nxt_cur.num = gear_numerator_counts; // RL16
          nxt_cur.den = gear_denominator_counts; // RL16
        end
        nxt_cur.acc = '0;
        nxt_cur.sts.done = 1'b1; // RL2
        nxt_cur.sts.in_progress = 1'b1; // RL20
        nxt_cur.st = mig_pkg::ST_GEAR;
      end
    end else begin
      // Accepted drops only once the request is gone and no fault is active.
      if (!cur_ff.run_s[1] && !cur_ff.gear_s[1] && !dc.faulted) begin
        nxt_cur.sts.accepted = 1'b0; // RL1
      end
      // A drive fault during an operation aborts it as an error.
      if (busy && dc.faulted) begin
        nxt_cur.sts.error = 1'b1; // RL3
        nxt_cur.err = mig_pkg::ERR_FAULTED; // RL3
        nxt_cur.sts.done = 1'b0;
        nxt_cur.sts.in_progress = 1'b0;
        nxt_cur.st = mig_pkg::ST_IDLE;
      end else begin
        unique case (cur_ff.st)
          mig_pkg::ST_IDLE: begin
          end
          mig_pkg::ST_RUN: begin
            if (cur_ff.tr_s[1]) begin
              nxt_cur.sts.in_progress = 1'b0; // RL4
              nxt_cur.sts.complete = cur_ff.sts.in_progress; // RL5
              nxt_cur.exec_idx = mig_pkg::IDX_NONE;
              nxt_cur.st = mig_pkg::ST_IDLE;
            end
          end
          mig_pkg::ST_GEAR: begin
            // Gearing stays active regardless of the request level.
            if (pul_rise && cur_ff.den != '0) begin
              sum = {1'b0, cur_ff.acc} + {1'b0, cur_ff.num}; // RL12
              if (sum >= {1'b0, cur_ff.den}) begin
                sum = sum - {1'b0, cur_ff.den}; // RL14
                nxt_cur.step = 1'b1; // RL12
              end
              nxt_cur.acc = sum[mig_pkg::CNT_W-1:0];
            end
            if (dc.axis_stop_busy || dc.servo_off_busy) begin
              nxt_cur.sts.in_progress = 1'b0; // RL20
              nxt_cur.st = mig_pkg::ST_HOLD;
            end
          end
          mig_pkg::ST_HOLD: begin
            // Fixed policy leaves the ratio untouched, preserving position scaling.
            nxt_cur.st = mig_pkg::ST_IDLE; // RL15
          end
        endcase
      end
    end
    // Follow mode is registered with the state so the output comes from a flip-flop.
    nxt_cur.follow = (nxt_cur.st == mig_pkg::ST_GEAR);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register; the ratio resets to the existing fixed defaults.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cur_ff <= '0;
      cur_ff.st <= mig_pkg::ST_IDLE;
      cur_ff.num <= mig_pkg::DEF_NUM; // RL15
      cur_ff.den <= mig_pkg::DEF_DEN; // RL15
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs straight from the state register.
  assign command_accepted_flag = cur_ff.sts.accepted;
  assign transfer_done_flag = cur_ff.sts.done;
  assign command_error_flag = cur_ff.sts.error;
  assign motion_in_progress_flag = cur_ff.sts.in_progress;
  assign motion_complete_flag = cur_ff.sts.complete;
  assign error_cause_code = cur_ff.err;
  assign executing_program_index = cur_ff.exec_idx; // RL8
  assign program_run_command = cur_ff.issue;
  assign stored_motion_program = cur_ff.prog;
  assign pulse_follow_mode = cur_ff.follow;
  assign motor_step_pulse = cur_ff.step;
  assign active_gear_numerator = cur_ff.num;
  assign active_gear_denominator = cur_ff.den;

endmodule : mig_command

//--- dv/mig_properties.sv
// Concurrent checks on the command interpreter ports.
// Assumes it is bound to every mig_command instance.
`timescale 1ns/1ns
module mig_properties (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic command_accepted_flag,
  input wire logic transfer_done_flag,
  input wire logic command_error_flag,
  input wire logic motion_in_progress_flag,
  input wire logic motion_complete_flag,
  input wire logic [mig_pkg::ERR_W-1:0] error_cause_code,
  input wire logic [mig_pkg::IDX_W-1:0] executing_program_index,
  input wire logic program_run_command,
  input wire logic pulse_follow_mode,
  input wire logic [mig_pkg::CNT_W-1:0] active_gear_numerator,
  input wire logic [mig_pkg::CNT_W-1:0] active_gear_denominator
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // A refusal never claims success, and its code lives exactly as long as the flag.
  a_done_err_excl: assert property (!(transfer_done_flag && command_error_flag))
    else $error("done and error together");
  a_code_with_err: assert property (command_error_flag == (error_cause_code != mig_pkg::ERR_NONE))
    else $error("error code out of step with flag");
  a_err_accepted: assert property ($rose(command_error_flag) |-> command_accepted_flag)
    else $error("error without accept");
  a_done_accepted: assert property ($rose(transfer_done_flag) |-> command_accepted_flag)
    else $error("done without accept");
  // The run strobe is one cycle and starts motion at once.
  a_run_starts_ip: assert property (program_run_command |-> motion_in_progress_flag ##1 !program_run_command)
    else $error("run strobe without motion");
  a_run_index_range: assert property (program_run_command |-> executing_program_index inside {[1:99]})
    else $error("run with index out of range");
  a_complete_ends_ip: assert property ($rose(motion_complete_flag) |-> $past(motion_in_progress_flag)
    && !motion_in_progress_flag && executing_program_index == mig_pkg::IDX_NONE)
    else $error("completion not tied to end of motion");
  a_gear_holds_ip: assert property (pulse_follow_mode |-> motion_in_progress_flag)
    else $error("gearing without in progress");
  a_ratio_steady: assert property (pulse_follow_mode && $past(pulse_follow_mode)
    |-> $stable(active_gear_numerator) && $stable(active_gear_denominator))
    else $error("ratio moved while gearing");
  c_run_complete: cover property ($rose(motion_complete_flag));
  c_refusal: cover property ($rose(command_error_flag));
  c_gearing: cover property ($rose(pulse_follow_mode));
endmodule : mig_properties

bind mig_command mig_properties u_mig_properties (.core_clk(core_clk), .rstn(rstn),
  .command_accepted_flag(command_accepted_flag), .transfer_done_flag(transfer_done_flag),
  .command_error_flag(command_error_flag), .motion_in_progress_flag(motion_in_progress_flag),
  .motion_complete_flag(motion_complete_flag), .error_cause_code(error_cause_code),
  .executing_program_index(executing_program_index), .program_run_command(program_run_command),
  .pulse_follow_mode(pulse_follow_mode), .active_gear_numerator(active_gear_numerator),
  .active_gear_denominator(active_gear_denominator));

//--- dv/mig_ctrl_model.sv
// Far-side model: reports target reached after a run and sends master pulse bursts.
// Assumes burst_go is a one-cycle strobe from the bench.
`timescale 1ns/1ns
module mig_ctrl_model #(parameter int REACH_DLY = 40) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic program_run_command,
  input wire logic motion_complete_flag,
  input wire logic burst_go,
  input wire logic [7:0] burst_len,
  output logic target_reached_flag,
  output logic master_pulse
);
  int dly, halves, tick;
  // Reached drops once completion shows, so a stale level never ends the next move.
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      dly <= 0;
      halves <= 0;
      tick <= 0;
      target_reached_flag <= 1'b0;
      master_pulse <= 1'b0;
    end else begin
      if (program_run_command) dly <= REACH_DLY;
      else if (dly > 0) dly <= dly - 1;
      target_reached_flag <= (dly == 1) || (target_reached_flag && !motion_complete_flag);
      tick <= (tick + 1) % 4;
      if (burst_go) halves <= 2 * burst_len;
      else if (halves > 0 && tick == 3) begin
        halves <= halves - 1;
        master_pulse <= ~master_pulse;
      end
    end
  end
endmodule : mig_ctrl_model

//--- dv/testbench.sv
// Bench of the command interpreter: run, refusal and gear sequences.
// Assumes stored programs are configured before any run request.
`timescale 1ns/1ns
module testbench;
  logic core_clk, rstn, run_request, gear_request, policy, burst_go, reached, mpulse, runc, step;
  logic acc, done, err, ip, cmp, pfm;
  logic [6:0] idx_req, idx, prog;
  logic [7:0] code, burst_len;
  logic [31:0] num, den, anum, aden;
  logic [1:0] gsel;
  mig_pkg::mig_drive_t cond;
  int err_total, comparisons, steps;
  localparam logic [6:0] GOOD = 7'h51;
  logic [6:0] bad_idx [3] = '{7'h00, 7'h64, 7'h7F};
  logic [6:0] bad_cond [7] = '{7'h50, 7'h71, 7'h11, 7'h41, 7'h59, 7'h55, 7'h53};
  logic [7:0] bad_code [7] = '{8'h81, 8'h65, 8'h64, 8'h69, 8'h67, 8'h6B, 8'h6C};
  mig_command u_mig_command (.core_clk(core_clk), .rstn(rstn), .run_request(run_request),
    .gear_request(gear_request), .program_index_request(idx_req), .drive_cond(cond),
    .target_reached_flag(reached), .master_pulse(mpulse), .gear_ratio_policy(policy),
    .gear_numerator_counts(num), .gear_denominator_counts(den), .gear_select_inputs(gsel),
    .command_accepted_flag(acc), .transfer_done_flag(done), .command_error_flag(err),
    .motion_in_progress_flag(ip), .motion_complete_flag(cmp), .error_cause_code(code),
    .executing_program_index(idx), .program_run_command(runc), .stored_motion_program(prog),
    .pulse_follow_mode(pfm), .motor_step_pulse(step), .active_gear_numerator(anum),
    .active_gear_denominator(aden));
  mig_ctrl_model u_mig_ctrl_model (.core_clk(core_clk), .rstn(rstn), .program_run_command(runc),
    .motion_complete_flag(cmp), .burst_go(burst_go), .burst_len(burst_len),
    .target_reached_flag(reached), .master_pulse(mpulse));
  // Clock, step counter and a watchdog far beyond the expected run.
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (step === 1'b1) steps++;
  initial begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    print_verdict;
  end
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask : chk_val
  task automatic chk_bit(input logic got, input logic exp, input string what);
    chk_val({31'h0, got}, {31'h0, exp}, what);
  endtask : chk_bit
  // Raises one request and waits a bounded time for the accept answer.
  task automatic request(input logic gear, input logic [6:0] idx_v);
    int n;
    n = 0;
    @(posedge core_clk);
    idx_req <= idx_v;
    run_request <= !gear;
    gear_request <= gear;
    @(negedge core_clk);
    while (acc !== 1'b1 && n < 20) begin
      @(negedge core_clk);
      n++;
    end
    chk_bit(acc, 1'b1, "no accept");
  endtask : request
  task automatic release_req;
    @(posedge core_clk);
    run_request <= 1'b0;
    gear_request <= 1'b0;
    repeat (6) @(negedge core_clk);
  endtask : release_req
  task automatic wait_complete;
    int n;
    n = 0;
    while (cmp !== 1'b1 && n < 200) begin
      @(negedge core_clk);
      n++;
    end
    chk_bit(cmp, 1'b1, "no completion");
    chk_bit(ip, 1'b0, "still moving");
    chk_val({25'h0, idx}, 32'h0, "index kept");
  endtask : wait_complete
  // Gearing ends through an axis stop; the count is pulses times the ratio.
  task automatic gear_run(input logic pol, input logic [31:0] n_v, d_v, input logic [7:0] len, exp);
    @(posedge core_clk);
    policy <= pol;
    num <= n_v;
    den <= d_v;
    request(1'b1, 7'h00);
    chk_bit(pfm, 1'b1, "no follow");
    release_req;
    chk_bit(ip, 1'b1, "gear dropped");
    chk_val(anum, pol ? n_v : 32'h1, "numerator");
    chk_val(aden, pol ? d_v : 32'h1, "denominator");
    steps = 0;
    @(posedge core_clk);
    burst_len <= len;
    burst_go <= 1'b1;
    @(posedge core_clk);
    burst_go <= 1'b0;
    repeat (8 * len + 20) @(negedge core_clk);
    chk_val(steps, {24'h0, exp}, "step count");
    @(posedge core_clk);
    cond <= 7'h55;
    repeat (6) @(posedge core_clk);
    cond <= GOOD;
    repeat (6) @(negedge core_clk);
    chk_bit(ip, 1'b0, "gear not stopped");
    $display("test gear done");
  endtask : gear_run
  task automatic print_verdict;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  initial begin
    {rstn, run_request, gear_request, policy, burst_go, idx_req, burst_len} = '0;
    num = 32'h1;
    den = 32'h1;
    gsel = 2'h3;
    cond = GOOD;
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    @(negedge core_clk);
    chk_bit(acc, 1'b0, "accept after reset");
    chk_val(anum, 32'h1, "reset ratio");
    request(1'b0, 7'h05);
    chk_bit(done, 1'b1, "run not done");
    chk_bit(ip, 1'b1, "run not moving");
    chk_val({25'h0, idx}, 32'h5, "active index");
    chk_val({25'h0, prog}, 32'h5, "program source");
    release_req;
    wait_complete;
    $display("test run done");
    foreach (bad_idx[i]) begin
      request(1'b0, bad_idx[i]);
      chk_val({24'h0, code}, 32'h73, "index refusal");
      release_req;
    end
    request(1'b0, 7'h63);
    chk_bit(err, 1'b0, "top index refused");
    release_req;
    request(1'b0, 7'h02);
    chk_val({24'h0, code}, 32'h7F, "busy refusal");
    release_req;
    wait_complete;
    $display("test index done");
    foreach (bad_cond[i]) begin
      @(posedge core_clk);
      cond <= bad_cond[i];
      repeat (4) @(posedge core_clk);
      request(1'b0, 7'h01);
      chk_bit(done, 1'b0, "refused but done");
      chk_val({24'h0, code}, {24'h0, bad_code[i]}, "refusal code");
      @(posedge core_clk);
      cond <= GOOD;
      release_req;
      chk_bit(err, 1'b1, "error cleared early");
    end
    $display("test refusal done");
    gear_run(1'b0, 32'h3, 32'h5, 8'h04, 8'h04);
    // Numerator stands for the motor resolution; homing would follow this variable run.
    gear_run(1'b1, 32'h1, 32'h2, 8'h06, 8'h03);
    print_verdict;
  end
endmodule : testbench
